// >>> design/doc_output_ctrl.sv
// Output coding, routing, tri-state and power control of a dual converter
`timescale 1ns/1ps
module doc_output_ctrl #(
    parameter logic [doc_pkg::CNT_W-1:0] SLEEP_RECOVERY_CYCLES =
        doc_pkg::CNT_W'(doc_pkg::SLEEP_RECOVERY_CYC)
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [doc_pkg::SAMPLE_W-1:0] chan_a_sample_word,
    input wire logic chan_a_over_range,
    input wire logic chan_a_under_range,
    input wire logic [doc_pkg::SAMPLE_W-1:0] chan_b_sample_word,
    input wire logic chan_b_over_range,
    input wire logic chan_b_under_range,
    output logic [doc_pkg::SAMPLE_W-1:0] first_output_bus,
    output logic first_bus_range_flag,
    output logic first_bus_oe_n,
    output logic [doc_pkg::SAMPLE_W-1:0] second_output_bus,
    output logic second_bus_range_flag,
    output logic second_bus_oe_n,
    output logic stabilizer_enable,
    output logic stabilizer_locked
);

    typedef struct packed {
        logic [doc_pkg::CTRL_W-1:0] ctrl;
        logic [doc_pkg::CNT_W-1:0] nap_cnt;
        logic [31:0] prdata;
        logic pslverr;
        logic [doc_pkg::SAMPLE_W-1:0] samp_a;
        logic ovr_a;
        logic und_a;
        logic [doc_pkg::SAMPLE_W-1:0] samp_b;
        logic ovr_b;
        logic und_b;
        logic [doc_pkg::SAMPLE_W-1:0] bus1;
        logic flag1;
        logic oe1_n;
        logic [doc_pkg::SAMPLE_W-1:0] bus2;
        logic flag2;
        logic oe2_n;
        logic [7:0] lock_cnt;
        logic locked;
    } doc_state_t;

    doc_state_t s_r;
    doc_state_t s_nxt;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] doc_sel(input logic [7:0] a);
        doc_sel = 2'h3;
        if (a[7:2] == doc_pkg::CTRL_OFS[7:2]) begin
            doc_sel = 2'h0;
        end else if (a[7:2] == doc_pkg::STATUS_OFS[7:2]) begin
            doc_sel = 2'h1;
        end else if (a[7:2] == doc_pkg::NAP_OFS[7:2]) begin
            doc_sel = 2'h2;
        end
    endfunction : doc_sel

    function automatic logic [doc_pkg::SAMPLE_W-1:0] doc_code(
        input logic [doc_pkg::SAMPLE_W-1:0] smp,
        input logic ovr,
        input logic und,
        input logic twos
    );
        logic [doc_pkg::SAMPLE_W-1:0] v;
        v = ovr ? doc_pkg::FULL_POS : (und ? doc_pkg::FULL_NEG : smp);
        doc_code = {v[doc_pkg::SAMPLE_W-1] ^ twos,
                    v[doc_pkg::SAMPLE_W-2:0]};
    endfunction : doc_code

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    doc_pkg::doc_mode_t mode;
    logic twos;
    logic swap;
    logic [1:0] pd;
    logic [1:0] hiz_n;

    assign mode = doc_pkg::doc_mode_t'(
        s_r.ctrl[doc_pkg::CTRL_MODE_LSB +: 2]);
    assign twos = (mode == doc_pkg::DOC_MODE_TWO_THIRD) ||
                  (mode == doc_pkg::DOC_MODE_VDD);
    assign stabilizer_enable = (mode == doc_pkg::DOC_MODE_THIRD) ||
                               (mode == doc_pkg::DOC_MODE_TWO_THIRD);
    assign swap = s_r.ctrl[doc_pkg::CTRL_SWAP];
    assign pd = {s_r.ctrl[doc_pkg::CTRL_PD_B], s_r.ctrl[doc_pkg::CTRL_PD_A]};
    assign hiz_n = {s_r.ctrl[doc_pkg::CTRL_HIZ_B],
                    s_r.ctrl[doc_pkg::CTRL_HIZ_A]};

    // ------------------------------------------------------------
    // Channel power controllers
    // ------------------------------------------------------------
    doc_pkg::doc_pwr_t ch_state [2];
    logic [1:0] ch_drive_n;
    logic [1:0] ch_valid;

    for (genvar i = 0; i < 2; i++) begin : g_chan
        doc_chan_power #(
            .SLEEP_CYCLES(SLEEP_RECOVERY_CYCLES)
        ) u_pwr (
            .clock(clock),
            .nrst(nrst),
            .power_down_request(pd[i]),
            .output_hiz_n(hiz_n[i]),
            .nap_cycles(s_r.nap_cnt),
            .state(ch_state[i]),
            .drive_n(ch_drive_n[i]),
            .data_valid(ch_valid[i])
        );
    end

    // ------------------------------------------------------------
    // Output coding and routing
    // ------------------------------------------------------------
    logic [doc_pkg::SAMPLE_W-1:0] code_a;
    logic [doc_pkg::SAMPLE_W-1:0] code_b;
    logic range_a;
    logic range_b;

    assign code_a = doc_code(s_r.samp_a, s_r.ovr_a, s_r.und_a, twos);
    assign code_b = doc_code(s_r.samp_b, s_r.ovr_b, s_r.und_b, twos);
    assign range_a = s_r.ovr_a || s_r.und_a;
    assign range_b = s_r.ovr_b || s_r.und_b;

    // ------------------------------------------------------------
    // Bus access
    // ------------------------------------------------------------
    logic setup;
    logic access;
    logic [1:0] sel;
    logic [31:0] status;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign sel = doc_sel(paddr);
    assign status = {23'h000000, s_r.locked, stabilizer_enable, twos,
                     ch_state[1], ch_state[0], ch_valid};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.samp_a = chan_a_sample_word;
        s_nxt.ovr_a = chan_a_over_range;
        s_nxt.und_a = chan_a_under_range && !chan_a_over_range;
        s_nxt.samp_b = chan_b_sample_word;
        s_nxt.ovr_b = chan_b_over_range;
        s_nxt.und_b = chan_b_under_range && !chan_b_over_range;
        if (swap) begin
            s_nxt.bus1 = code_a;
            s_nxt.flag1 = range_a;
            s_nxt.oe1_n = ch_drive_n[0];
            s_nxt.bus2 = code_b;
            s_nxt.flag2 = range_b;
            s_nxt.oe2_n = ch_drive_n[1];
        end else begin
            s_nxt.bus1 = code_b;
            s_nxt.flag1 = range_b;
            s_nxt.oe1_n = ch_drive_n[1];
            s_nxt.bus2 = code_a;
            s_nxt.flag2 = range_a;
            s_nxt.oe2_n = ch_drive_n[0];
        end
        if (!stabilizer_enable) begin
            s_nxt.lock_cnt = '0;
            s_nxt.locked = 1'b0;
        end else if (!s_r.locked) begin
            if (s_r.lock_cnt == doc_pkg::RELOCK_LAST) begin
                s_nxt.locked = 1'b1;
            end else begin
                s_nxt.lock_cnt = s_r.lock_cnt + 8'h01;
            end
        end
        if (setup) begin
            s_nxt.pslverr = (sel == 2'h3) || (pwrite && sel == 2'h1);
            case (sel)
                2'h0: s_nxt.prdata = {25'h0000000, s_r.ctrl};
                2'h1: s_nxt.prdata = status;
                2'h2: s_nxt.prdata = {12'h000, s_r.nap_cnt};
                default: s_nxt.prdata = 32'h00000000;
            endcase
        end
        if (access && pwrite && !s_r.pslverr) begin
            case (sel)
                2'h0: s_nxt.ctrl = pwdata[doc_pkg::CTRL_W-1:0];
                2'h2: s_nxt.nap_cnt = pwdata[doc_pkg::CNT_W-1:0];
                default: s_nxt.ctrl = s_r.ctrl;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_r <= '{ctrl: doc_pkg::CTRL_RST,
                     nap_cnt: doc_pkg::NAP_RST,
                     oe1_n: 1'b1,
                     oe2_n: 1'b1,
                     default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = s_r.prdata;
    assign pready = 1'b1;
    assign pslverr = access ? s_r.pslverr : 1'b0;
    assign first_output_bus = s_r.bus1;
    assign first_bus_range_flag = s_r.flag1;
    assign first_bus_oe_n = s_r.oe1_n;
    assign second_output_bus = s_r.bus2;
    assign second_bus_range_flag = s_r.flag2;
    assign second_bus_oe_n = s_r.oe2_n;
    assign stabilizer_locked = s_r.locked;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_offset_mid: assert property (
        swap && !twos && !range_a && s_r.samp_a == doc_pkg::MID_OB &&
        mode inside {doc_pkg::DOC_MODE_GND, doc_pkg::DOC_MODE_THIRD}
        |=> first_output_bus == 14'h2000)
        else $error("offset binary mid scale wrong");
    a_twos_mid: assert property (
        !swap && !range_a && s_r.samp_a == doc_pkg::MID_OB &&
        mode inside {doc_pkg::DOC_MODE_TWO_THIRD, doc_pkg::DOC_MODE_VDD}
        |=> second_output_bus == doc_pkg::MID_TC)
        else $error("two's complement mid scale wrong");
    a_stab_mode: assert property (
        stabilizer_enable == (s_r.ctrl[doc_pkg::CTRL_MODE_LSB] ^
                              s_r.ctrl[doc_pkg::CTRL_MODE_LSB + 1]))
        else $error("stabilizer level decode wrong");
    a_range_flag: assert property (
        swap && (s_r.ovr_b || s_r.und_b) ##1 !$changed(swap)
        |-> second_bus_range_flag)
        else $error("range flag not raised");
    a_clamp_over: assert property (
        swap && s_r.ovr_a && !twos |=> first_output_bus == 14'h3FFF &&
        first_bus_range_flag)
        else $error("overrange clamp wrong");
    a_clamp_under: assert property (
        swap && s_r.und_b && !s_r.ovr_b && !twos
        |=> second_output_bus == 14'h0000 && second_bus_range_flag)
        else $error("underrange clamp wrong");
    a_hiz_bus: assert property (
        swap && hiz_n[0] |=> first_bus_oe_n)
        else $error("first bus driven while disabled");
    a_swap_low: assert property (
        !swap && !ch_drive_n[0] |=> !second_bus_oe_n ##0
        second_output_bus == $past(code_a))
        else $error("swap low routing wrong");
    a_nap_hiz: assert property (
        ch_state[0] == doc_pkg::DOC_NAP && swap |=> first_bus_oe_n)
        else $error("napping channel drives bus");
    a_relock_time: assert property (
        $rose(stabilizer_enable) |-> !stabilizer_locked [*8])
        else $error("stabilizer locked too early");

    // ------------------------------------------------------------
    // Coding, routing, power and stabilizer checks
    // ------------------------------------------------------------
    a_mode_coding: assert property (
        swap && !range_a |=> first_output_bus[doc_pkg::SAMPLE_W-1] ==
        ($past(s_r.samp_a[doc_pkg::SAMPLE_W-1]) ^
         $past(s_r.ctrl[doc_pkg::CTRL_MODE_LSB + 1])))
        else $error("coding does not follow format level");
    a_same_coding: assert property (
        !range_a && !range_b |=> (first_output_bus[doc_pkg::SAMPLE_W-1] ^
        second_output_bus[doc_pkg::SAMPLE_W-1]) ==
        ($past(s_r.samp_a[doc_pkg::SAMPLE_W-1]) ^
         $past(s_r.samp_b[doc_pkg::SAMPLE_W-1])))
        else $error("channels coded differently");
    a_flag_low: assert property (
        swap && !range_a |=> !first_bus_range_flag)
        else $error("range flag raised in range");
    a_indep_power: assert property (
        !pd[1] && ch_state[1] == doc_pkg::DOC_RUN
        |=> ch_state[1] == doc_pkg::DOC_RUN)
        else $error("channel B disturbed by channel A");
    a_sleep_hiz: assert property (
        ch_state[1] == doc_pkg::DOC_SLEEP && swap |=> second_bus_oe_n)
        else $error("sleeping channel drives bus");
    a_swap_high: assert property (
        swap |=> first_output_bus == $past(code_a) &&
        first_bus_range_flag == $past(range_a) &&
        second_output_bus == $past(code_b))
        else $error("swap high routing wrong");
    a_swap_low_b: assert property (
        !swap |=> first_output_bus == $past(code_b) &&
        first_bus_range_flag == $past(range_b))
        else $error("swap low routing of channel B wrong");
    a_low_bits: assert property (
        swap && !range_a |=> first_output_bus[doc_pkg::SAMPLE_W-2:0] ==
        $past(s_r.samp_a[doc_pkg::SAMPLE_W-2:0]))
        else $error("low bits altered by coding");
    a_lock_clear: assert property (
        !stabilizer_enable |=> !stabilizer_locked)
        else $error("stabilizer lock kept while off");

    c_nap_cycle: cover property (
        ch_state[0] == doc_pkg::DOC_NAP ##1
        ch_state[0] == doc_pkg::DOC_RECOVER ##[1:300] ch_valid[0]);
    c_over_on_bus: cover property (first_bus_range_flag && !first_bus_oe_n);
    c_swap_both: cover property (swap ##1 !swap ##1 swap);
    c_bus_error: cover property (access && pslverr);
    c_sleep_cycle: cover property (ch_state[1] == doc_pkg::DOC_SLEEP ##1
        ch_state[1] == doc_pkg::DOC_RECOVER);

endmodule : doc_output_ctrl

// >>> include/doc_pkg.sv
// Constants and types shared by the dual output control block
package doc_pkg;

    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int SAMPLE_W = 14;
    localparam int CNT_W = 20;
    localparam int CLK_PERIOD_NS = 10;
    localparam int NAP_RECOVERY_CYCLES = 100;
    localparam int SLEEP_RECOVERY_US = 1000;
    localparam int SLEEP_RECOVERY_CYC =
        (SLEEP_RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELOCK_CYCLES = 100;
    localparam logic [7:0] RELOCK_LAST = 8'(RELOCK_CYCLES - 1);

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] NAP_OFS = 8'h08;
    localparam int CTRL_W = 7;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_PD_A = 2;
    localparam int CTRL_PD_B = 3;
    localparam int CTRL_HIZ_A = 4;
    localparam int CTRL_HIZ_B = 5;
    localparam int CTRL_SWAP = 6;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h40;
    localparam logic [CNT_W-1:0] NAP_RST = CNT_W'(NAP_RECOVERY_CYCLES);

    // ------------------------------------------------------------
    // Sample codes
    // ------------------------------------------------------------
    localparam logic [SAMPLE_W-1:0] MID_OB = 14'h2000;
    localparam logic [SAMPLE_W-1:0] MID_TC = 14'h0000;
    localparam logic [SAMPLE_W-1:0] FULL_POS = 14'h3FFF;
    localparam logic [SAMPLE_W-1:0] FULL_NEG = 14'h0000;

    typedef enum logic [1:0] {
        DOC_MODE_GND = 2'b00,
        DOC_MODE_THIRD = 2'b01,
        DOC_MODE_TWO_THIRD = 2'b10,
        DOC_MODE_VDD = 2'b11
    } doc_mode_t;

    typedef enum logic [1:0] {
        DOC_RUN = 2'b00,
        DOC_NAP = 2'b01,
        DOC_SLEEP = 2'b10,
        DOC_RECOVER = 2'b11
    } doc_pwr_t;

endpackage : doc_pkg

// >>> design/doc_chan_power.sv
// Power state and recovery tracking of one converter channel
`timescale 1ns/1ps
module doc_chan_power #(
    parameter logic [doc_pkg::CNT_W-1:0] SLEEP_CYCLES =
        doc_pkg::CNT_W'(doc_pkg::SLEEP_RECOVERY_CYC)
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic power_down_request,
    input wire logic output_hiz_n,
    input wire logic [doc_pkg::CNT_W-1:0] nap_cycles,
    output doc_pkg::doc_pwr_t state,
    output logic drive_n,
    output logic data_valid
);

    typedef struct packed {
        doc_pkg::doc_pwr_t st;
        logic [doc_pkg::CNT_W-1:0] cnt;
    } doc_pwr_state_t;

    doc_pwr_state_t s_r;
    doc_pwr_state_t s_nxt;
    logic [doc_pkg::CNT_W-1:0] nap_len;
    logic [doc_pkg::CNT_W-1:0] sleep_len;

    assign nap_len = (nap_cycles == '0) ? 20'h00001 : nap_cycles;
    assign sleep_len = (SLEEP_CYCLES == '0) ? 20'h00001 : SLEEP_CYCLES;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            doc_pkg::DOC_RUN: begin
                if (power_down_request) begin
                    s_nxt.st = output_hiz_n ? doc_pkg::DOC_SLEEP
                                            : doc_pkg::DOC_NAP;
                end
            end
            doc_pkg::DOC_NAP, doc_pkg::DOC_SLEEP: begin
                if (power_down_request) begin
                    s_nxt.st = output_hiz_n ? doc_pkg::DOC_SLEEP
                                            : doc_pkg::DOC_NAP;
                end else begin
                    s_nxt.st = doc_pkg::DOC_RECOVER;
                    s_nxt.cnt = (s_r.st == doc_pkg::DOC_NAP) ? nap_len
                                                            : sleep_len;
                end
            end
            doc_pkg::DOC_RECOVER: begin
                if (power_down_request) begin
                    s_nxt.st = output_hiz_n ? doc_pkg::DOC_SLEEP
                                            : doc_pkg::DOC_NAP;
                end else if (s_r.cnt <= 20'h00001) begin
                    s_nxt.st = doc_pkg::DOC_RUN;
                    s_nxt.cnt = '0;
                end else begin
                    s_nxt.cnt = s_r.cnt - 20'h00001;
                end
            end
            default: begin
                s_nxt.st = doc_pkg::DOC_RUN;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_r <= '{st: doc_pkg::DOC_RUN, cnt: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign state = s_r.st;
    assign drive_n = output_hiz_n || (s_r.st == doc_pkg::DOC_NAP) ||
                     (s_r.st == doc_pkg::DOC_SLEEP);
    assign data_valid = (s_r.st == doc_pkg::DOC_RUN);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_sleep_entry: assert property (
        power_down_request && output_hiz_n |=> state == doc_pkg::DOC_SLEEP)
        else $error("sleep not entered");
    a_nap_entry: assert property (
        power_down_request && !output_hiz_n |=> state == doc_pkg::DOC_NAP)
        else $error("nap not entered");
    a_run_holds: assert property (
        state == doc_pkg::DOC_RUN && !power_down_request
        |=> state == doc_pkg::DOC_RUN && drive_n == output_hiz_n)
        else $error("normal run disturbed");
    a_low_power_hiz: assert property (
        state inside {doc_pkg::DOC_NAP, doc_pkg::DOC_SLEEP}
        |-> drive_n && !data_valid)
        else $error("outputs driven while powered down");
    a_recover_end: assert property (
        state == doc_pkg::DOC_RECOVER && s_r.cnt == 20'h00001 &&
        !power_down_request |=> data_valid)
        else $error("recovery did not end");
    a_nap_wait: assert property (
        state == doc_pkg::DOC_NAP && !power_down_request
        |=> !data_valid && s_r.cnt == nap_len)
        else $error("nap recovery count wrong");

endmodule : doc_chan_power

// >>> verification/doc_rx_latch.sv
// Receiver latch model that captures one parallel output bus
`timescale 1ns/1ps
module doc_rx_latch (
    input wire logic clock,
    input wire logic [doc_pkg::SAMPLE_W-1:0] bus_word,
    input wire logic bus_flag,
    input wire logic bus_oe_n,
    output logic [doc_pkg::SAMPLE_W-1:0] cap_word,
    output logic cap_flag
);
    // Captures only while the bus is driven; enable is not toggled per sample
    always @(posedge clock) begin
        if (bus_oe_n === 1'b0) begin
            cap_word <= bus_word;
            cap_flag <= bus_flag;
        end
    end
endmodule : doc_rx_latch

// >>> verification/doc_output_ctrl_tb_top.sv
// Self-checking bench of the dual output control block
`timescale 1ns/1ps
module doc_output_ctrl_tb_top;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, s_rd, rd;
    logic pready, pslverr, s_err, err;
    logic [13:0] a_word = 14'h0, b_word = 14'h0, bus1, bus2, cap1, cap2;
    logic a_ovr = 1'b0, a_und = 1'b0, b_ovr = 1'b0, b_und = 1'b0;
    logic flag1, flag2, oe1_n, oe2_n, stab_en, stab_lock, cf1, cf2;
    int mismatches = 0, cmp_count = 0, n;

    always #5 clock = ~clock;
    always @(posedge clock) begin
        s_rd <= prdata;
        s_err <= pslverr;
    end

    doc_output_ctrl #(.SLEEP_RECOVERY_CYCLES(20'd50)) dut (
        .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan_a_sample_word(a_word),
        .chan_a_over_range(a_ovr), .chan_a_under_range(a_und),
        .chan_b_sample_word(b_word), .chan_b_over_range(b_ovr),
        .chan_b_under_range(b_und), .first_output_bus(bus1),
        .first_bus_range_flag(flag1), .first_bus_oe_n(oe1_n),
        .second_output_bus(bus2), .second_bus_range_flag(flag2),
        .second_bus_oe_n(oe2_n), .stabilizer_enable(stab_en),
        .stabilizer_locked(stab_lock));
    doc_rx_latch rx1 (.clock(clock), .bus_word(bus1), .bus_flag(flag1),
        .bus_oe_n(oe1_n), .cap_word(cap1), .cap_flag(cf1));
    doc_rx_latch rx2 (.clock(clock), .bus_word(bus2), .bus_flag(flag2),
        .bus_oe_n(oe2_n), .cap_word(cap2), .cap_flag(cf2));

    // ------------------------------------------------------------
    // Bus access and comparison
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clock);
        rd = s_rd;
        err = s_err;
        @(posedge clock);
    endtask : apb

    task automatic settle;
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask : settle

    task automatic drive(input logic [13:0] a, b, input logic [3:0] f);
        a_word <= a;
        b_word <= b;
        {a_ovr, a_und, b_ovr, b_und} <= f;
    endtask : drive

    task automatic chkbus(input logic [13:0] e1, input logic f1,
                          input logic [13:0] e2, input logic f2);
        settle();
        chk("bus1", e1, bus1);
        chk("flag1", f1, flag1);
        chk("bus2", e2, bus2);
        chk("flag2", f2, flag2);
        chk("rx1", e1, cap1);
        chk("rx1 flag", f1, cf1);
        chk("rx2", e2, cap2);
        chk("rx2 flag", f2, cf2);
        @(posedge clock);
    endtask : chkbus

    task automatic poll(input int b);
        n = 0;
        do begin
            apb(1'b0, 8'h04, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 100);
        if (rd[b] !== 1'b1) mismatches++;
    endtask : poll

    function automatic logic [13:0] enc(logic [13:0] r, logic ov, un, tc);
        logic [13:0] v;
        v = ov ? 14'h3FFF : (un ? 14'h0000 : r);
        return {v[13] ^ tc, v[12:0]};
    endfunction : enc

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        repeat (9) @(posedge clock);
        @(negedge clock);
        chk("oe1 in reset", 1'b1, oe1_n);
        @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl reset", 32'h40, rd);
        apb(1'b0, 8'h08, 32'h0);
        chk("nap reset", 32'd100, rd);
        apb(1'b1, 8'h08, 32'hFFF00064);
        apb(1'b0, 8'h08, 32'h0);
        chk("nap write", 32'h00000064, rd);
        apb(1'b0, 8'h3C, 32'h0);
        chk("unmapped err", 1'b1, err);
        apb(1'b1, 8'h04, 32'hFF);
        chk("status write err", 1'b1, err);
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 8'h00, 32'h40 | 32'(m));
            drive(14'h1234, 14'h0ABC, 4'b0000);
            chkbus(enc(14'h1234, 1'b0, 1'b0, m[1]), 1'b0,
                   enc(14'h0ABC, 1'b0, 1'b0, m[1]), 1'b0);
            chk("stab", (m == 1 || m == 2), stab_en);
            drive(14'h0001, 14'h0002, 4'b1001);
            chkbus(enc(14'h0001, 1'b1, 1'b0, m[1]), 1'b1,
                   enc(14'h0002, 1'b0, 1'b1, m[1]), 1'b1);
        end
        $display("test coding done");
        apb(1'b1, 8'h00, 32'h41);
        repeat (50) @(posedge clock);
        chk("not yet locked", 1'b0, stab_lock);
        repeat (60) @(posedge clock);
        chk("locked", 1'b1, stab_lock);
        apb(1'b1, 8'h00, 32'h02);
        drive(14'h2000, 14'h2222, 4'b0000);
        chkbus(14'h0222, 1'b0, 14'h0000, 1'b0);
        apb(1'b1, 8'h00, 32'h50);
        settle();
        chk("hiz a oe1", 1'b1, oe1_n);
        chk("hiz a oe2", 1'b0, oe2_n);
        @(posedge clock);
        $display("test swap and hiz done");
        apb(1'b1, 8'h00, 32'h44);
        settle();
        chk("nap oe1", 1'b1, oe1_n);
        @(posedge clock);
        apb(1'b0, 8'h04, 32'h0);
        chk("nap state", 2'd1, rd[3:2]);
        apb(1'b1, 8'h00, 32'h40);
        apb(1'b0, 8'h04, 32'h0);
        chk("recover state", 3'd6, {rd[3:2], rd[0]});
        poll(0);
        chk("nap wait long", 1'b1, n > 20);
        chk("run state", 2'd0, rd[3:2]);
        apb(1'b1, 8'h00, 32'h68);
        settle();
        chk("sleep oe2", 1'b1, oe2_n);
        chk("a still runs", 1'b0, oe1_n);
        @(posedge clock);
        apb(1'b0, 8'h04, 32'h0);
        chk("sleep state", 2'd2, rd[5:4]);
        apb(1'b1, 8'h00, 32'h40);
        poll(1);
        chk("sleep wait long", 1'b1, n > 10);
        $display("test power done");
        tally_and_finish();
    end
endmodule : doc_output_ctrl_tb_top
